// ---- bench/decode_model.sv ----
// Behavioural instruction decoder that feeds one command per cycle to the sequencer
`timescale 1ns/1ps
`default_nettype none
module decode_model
  import pc_seq_pkg::*;
(
  input  wire logic clk,
  output var seq_cmd_t cmd
);
  initial cmd = '{op: HOLD, latch_we: 1'b0, latch_wdata: 8'h00, low_wdata: 8'h00, target: 11'h000};

  // ---------------------------------------------------------------
  // Command issue
  // ---------------------------------------------------------------
  // Launches at a rising edge; the sequencer executes it at the following edge
  task automatic send(input seq_op_t op, input logic we, input logic [LATCH_W-1:0] lw,
                      input logic [LOW_W-1:0] low, input logic [TARGET_W-1:0] tgt);
    @(posedge clk);
    cmd <= '{op: op, latch_we: we, latch_wdata: lw, low_wdata: low, target: tgt};
    @(negedge clk);
  endtask

  // Page bits are programmed before the call or jump this task issues
  task automatic branch(input seq_op_t op, input logic [1:0] page,
                        input logic [TARGET_W-1:0] tgt);
    send(HOLD, 1'b1, {3'h0, page, 3'h0}, 8'h00, 11'h000);
    send(op, 1'b0, 8'h00, 8'h00, tgt);
  endtask

  // Computed branch; a carry out of the low byte does not reach the page
  task automatic table_jump(input logic [LOW_W-1:0] off);
    send(ADD_WORKING_TO_FILE_OP, 1'b0, 8'h00, off, 11'h000);
  endtask
endmodule
`default_nettype wire

// ---- bench/pc_sequencer_tb.sv ----
// Self-checking testbench of the program counter sequencer
`timescale 1ns/1ps
`default_nettype none
module pc_sequencer_tb
  import pc_seq_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  seq_cmd_t           cmd;
  pc_t                pc_addr;
  logic [LOW_W-1:0]   low_rd;
  logic [LATCH_W-1:0] latch_rd;
  int                 bad_count = 0;
  int                 checks = 0;

  always #5 clk = ~clk;

  pc_sequencer pc_sequencer_inst (.CLK(clk), .RST(rst), .CMD(cmd), .PC_ADDR(pc_addr),
    .PC_LOW_RDATA(low_rd), .PC_LATCH_RDATA(latch_rd));
  decode_model decode_model_inst (.clk(clk), .cmd(cmd));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk_pc(input pc_t exp);
    checks++;
    if (pc_addr !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t pc got %h exp %h", $time, pc_addr, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic nop();
    decode_model_inst.send(HOLD, 1'b0, 8'h00, 8'h00, 11'h000);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    decode_model_inst.branch(JUMP, 2'h3, 11'h7FF);
    nop();
    chk_pc(13'h1FFF);
    do_reset();
    chk_pc(13'h0000);
    chk_byte(low_rd, 8'h00);
    chk_byte(latch_rd, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_low();
    decode_model_inst.send(HOLD, 1'b1, 8'hFF, 8'h00, 11'h000);
    decode_model_inst.send(WRITE_LOW, 1'b1, 8'h02, 8'h40, 11'h000);
    chk_byte(latch_rd, 8'h1F);
    nop();
    chk_pc(13'h1F40);
    chk_byte(low_rd, 8'h40);
    chk_byte(latch_rd, 8'h02);
    decode_model_inst.table_jump(8'hD0);
    nop();
    chk_pc(13'h0210);
    $display("low byte test done");
  endtask

  task automatic t_branch();
    logic [1:0] pg;
    for (int p = 0; p < 4; p++) begin
      pg = p[1:0];
      decode_model_inst.branch(JUMP, pg, 11'h5A5);
      nop();
      chk_pc({pg, 11'h5A5});
      decode_model_inst.send(CALL, 1'b0, 8'h00, 8'h00, 11'h0C3);
      decode_model_inst.send(HOLD, 1'b1, {3'h0, ~pg, 3'h0}, 8'h00, 11'h000);
      chk_pc({pg, 11'h0C3});
      decode_model_inst.send(RETURN_PLAIN, 1'b0, 8'h00, 8'h00, 11'h000);
      nop();
      chk_pc({pg, 11'h5A6});
      chk_byte(latch_rd, {3'h0, ~pg, 3'h0});
    end
    $display("branch test done");
  endtask

  task automatic t_returns();
    seq_op_t ops [3];
    ops = '{RETURN_PLAIN, RETURN_WITH_LITERAL_OP, RETURN_FROM_INTERRUPT_OP};
    foreach (ops[i]) begin
      decode_model_inst.branch(JUMP, 2'h1, 11'h200);
      decode_model_inst.send(CALL, 1'b0, 8'h00, 8'h00, 11'h0F0);
      decode_model_inst.send(ops[i], 1'b0, 8'h00, 8'h00, 11'h000);
      chk_pc(13'h08F0);
      nop();
      chk_pc(13'h0A01);
      chk_byte(latch_rd, 8'h08);
    end
    $display("return test done");
  endtask

  task automatic t_irq();
    decode_model_inst.branch(JUMP, 2'h2, 11'h050);
    decode_model_inst.send(IRQ_ENTRY, 1'b0, 8'h00, 8'h00, 11'h000);
    decode_model_inst.send(RETURN_FROM_INTERRUPT_OP, 1'b0, 8'h00, 8'h00, 11'h000);
    chk_pc(IRQ_VECTOR);
    decode_model_inst.send(STEP, 1'b0, 8'h00, 8'h00, 11'h000);
    chk_pc(13'h1050);
    nop();
    chk_pc(13'h1051);
    $display("interrupt test done");
  endtask

  // Ten nested calls, then ten returns: the stack wraps both ways
  task automatic t_circular();
    pc_t              ent [8];
    logic [PTR_W-1:0] ptr;
    pc_t              cur;
    logic [10:0]      tgt;
    do_reset();
    foreach (ent[i]) ent[i] = 13'h0000;
    ptr = 3'h0;
    cur = 13'h0000;
    for (int i = 0; i < 10; i++) begin
      tgt = 11'h100 + 11'(i * 16);
      decode_model_inst.send(CALL, 1'b0, 8'h00, 8'h00, tgt);
      ent[ptr] = cur + 13'h0001;
      ptr = ptr + 3'h1;
      cur = {2'b00, tgt};
    end
    nop();
    chk_pc(cur);
    for (int j = 0; j < 10; j++) begin
      decode_model_inst.send(RETURN_PLAIN, 1'b0, 8'h00, 8'h00, 11'h000);
      nop();
      ptr = ptr - 3'h1;
      if (j < 8) chk_pc(ent[ptr]);
      else chk_pc(ent[ptr]);
    end
    $display("circular stack test done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_low();
    t_branch();
    t_returns();
    t_irq();
    t_circular();
    wrap_up();
  end

  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- hdl/pc_seq_pkg.sv ----
// Constants and types shared by the program counter sequencer
package pc_seq_pkg;

  // ---------------------------------------------------------------
  // Widths and layout
  // ---------------------------------------------------------------
  localparam int PC_W           = 13;
  localparam int LOW_W          = 8;
  localparam int HIGH_W         = 5;
  localparam int TARGET_W       = 11;
  localparam int PAGE_W         = 2;
  localparam int PAGE_LSB       = 11;
  localparam int LATCH_W        = 8;
  localparam int LATCH_PAGE_MSB = 4;
  localparam int LATCH_PAGE_LSB = 3;
  localparam int LATCH_HIGH_MSB = 4;
  localparam int STACK_DEPTH    = 8;
  localparam int PTR_W          = 3;
  localparam int PROG_WORDS     = 8192;
  localparam int PAGE_WORDS     = 2048;

  // ---------------------------------------------------------------
  // Reset values and fixed addresses
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
  localparam logic [PC_W-1:0]    IRQ_VECTOR  = 13'h0004;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_MASK  = 8'h1F;
  localparam logic [PTR_W-1:0]   PTR_RESET   = 3'h0;
  localparam logic [PTR_W-1:0]   PTR_ONE     = 3'h1;
  localparam logic [PC_W-1:0]    PC_ONE      = 13'h0001;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [PC_W-1:0]  pc_t;
  typedef logic [PTR_W-1:0] ptr_t;

  typedef enum logic [3:0] {
    STEP                     = 4'b0000,
    HOLD                     = 4'b0001,
    WRITE_LOW                = 4'b0010,
    ADD_WORKING_TO_FILE_OP   = 4'b0011,
    CALL                     = 4'b0100,
    JUMP                     = 4'b0101,
    RETURN_PLAIN             = 4'b0110,
    RETURN_WITH_LITERAL_OP   = 4'b0111,
    RETURN_FROM_INTERRUPT_OP = 4'b1000,
    IRQ_ENTRY                = 4'b1001
  } seq_op_t;

  typedef struct packed {
    seq_op_t                  op;
    logic                     latch_we;
    logic [LATCH_W-1:0]       latch_wdata;
    logic [LOW_W-1:0]         low_wdata;
    logic [TARGET_W-1:0]      target;
  } seq_cmd_t;

endpackage

// ---- hdl/pc_sequencer.sv ----
// Program counter, high-byte latch and circular return stack of the core
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Keeps a 13-bit program counter; low byte readable and writable.
// RULE2 - Upper counter bits unreadable; loaded only through the high-byte latch.
// RULE3 - Any reset clears the upper counter bits to zero.
// RULE4 - Low-byte write loads counter bits 12..8 from latch bits 4..0.
// RULE5 - Call or jump gives 11 bits; bits 12..11 come from latch 4..3.
// RULE6 - Eight-entry 13-bit return stack, pointer hidden from software.
// RULE7 - Calls and interrupt entry push the return address.
// RULE8 - Plain return, literal return and interrupt return pop the stack.
// RULE9 - Return restores all 13 counter bits from the stack.
// RULE10 - Pushes and pops leave the high-byte latch untouched.
// RULE11 - Stack is circular; ninth push overwrites the first.
// RULE12 - No overflow or underflow indication of any kind.
// RULE13 - 8K-word program space in 2K pages chosen by top two bits.
// RULE14 - Software sets page bits before calls or jumps, and after returns.
// RULE15 - Software minds 256-byte block crossings in computed branches.
// RULE16 - Pointer wraps on pops too; empty pop returns the selected entry.
module pc_sequencer
  import pc_seq_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire seq_cmd_t   CMD,
  output pc_t             PC_ADDR,
  output logic [LOW_W-1:0]   PC_LOW_RDATA,
  output logic [LATCH_W-1:0] PC_LATCH_RDATA
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pc_t                pc_r;
  pc_t                pc_nxt;
  pc_t                ret_addr;
  pc_t                top;
  logic [LATCH_W-1:0] latch_r;
  logic [LATCH_W-1:0] latch_nxt;
  ptr_t               ptr_r;
  ptr_t               ptr_nxt;
  ptr_t               top_addr;
  logic               push;
  logic               pop;

  function automatic ptr_t ptr_step(input ptr_t ptr, input logic up);
    ptr_step = up ? PTR_W'(ptr + PTR_ONE) : PTR_W'(ptr - PTR_ONE);
  endfunction

  // ---------------------------------------------------------------
  // Stack control
  // ---------------------------------------------------------------
  assign push = (CMD.op == CALL) || (CMD.op == IRQ_ENTRY); // RULE7
  assign pop  = (CMD.op == RETURN_PLAIN) // RULE8
             || (CMD.op == RETURN_WITH_LITERAL_OP)
             || (CMD.op == RETURN_FROM_INTERRUPT_OP);

  // Pointer wraps both ways and never flags overflow or underflow
  always_comb begin
    if (push) begin
      ptr_nxt = ptr_step(ptr_r, 1'b1); // RULE11
    end else if (pop) begin
      ptr_nxt = ptr_step(ptr_r, 1'b0); // RULE16
    end else begin
      ptr_nxt = ptr_r;
    end
  end // RULE12

  // Top entry is prefetched for the pointer of the next cycle
  assign top_addr = ptr_step(ptr_nxt, 1'b0);

  // Pointer lives only here; no port exposes it
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_r <= PTR_RESET;
    end else begin
      ptr_r <= ptr_nxt; // RULE6
    end
  end

  pc_stack_mem u_stack (
    .clk       (CLK),
    .rst       (RST),
    .wr_en     (push),
    .wr_addr   (ptr_r),
    .wr_data   (ret_addr),
    .rd_addr   (top_addr),
    .rd_data_r (top)
  ); // RULE6

  // ---------------------------------------------------------------
  // Next address selection
  // ---------------------------------------------------------------
  pc_target_mux u_mux (
    .cmd      (CMD),
    .pc       (pc_r),
    .latch    (latch_r),
    .top      (top),
    .pc_nxt   (pc_nxt),
    .ret_addr (ret_addr)
  );

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // Thirteen bits span 8K words; bits 12..11 select the 2K page
  always_ff @(posedge CLK) begin
    if (RST) begin
      pc_r <= PC_RESET; // RULE3
    end else begin
      pc_r <= pc_nxt; // RULE1 RULE13
    end
  end

  // ---------------------------------------------------------------
  // High-byte latch
  // ---------------------------------------------------------------
  // Only an explicit latch write changes it; stack traffic never does
  assign latch_nxt = CMD.latch_we ? (CMD.latch_wdata & LATCH_MASK) : latch_r; // RULE10

  always_ff @(posedge CLK) begin
    if (RST) begin
      latch_r <= LATCH_RESET;
    end else begin
      latch_r <= latch_nxt; // RULE2
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Only the low byte of the counter is visible to software
  assign PC_ADDR        = pc_r;
  assign PC_LOW_RDATA   = pc_r[LOW_W-1:0]; // RULE1 RULE2
  assign PC_LATCH_RDATA = latch_r;

  // ---------------------------------------------------------------
  // Reference stack for the checks
  // ---------------------------------------------------------------
  // Kept apart from the storage so a bypass or pointer slip shows up
  pc_t  shadow_r [STACK_DEPTH];
  ptr_t shadow_ptr_r;
  pc_t  shadow_top;
  pc_t  push_value;

  assign push_value = (CMD.op == CALL) ? PC_W'(pc_r + PC_ONE) : pc_r;
  assign shadow_top = shadow_r[PTR_W'(shadow_ptr_r - PTR_ONE)];

  always_ff @(posedge CLK) begin
    if (RST) begin
      shadow_ptr_r <= PTR_RESET;
    end else if (push) begin
      shadow_ptr_r <= PTR_W'(shadow_ptr_r + PTR_ONE);
    end else if (pop) begin
      shadow_ptr_r <= PTR_W'(shadow_ptr_r - PTR_ONE);
    end
  end

  for (genvar s = 0; s < STACK_DEPTH; s++) begin : g_shadow
    always_ff @(posedge CLK) begin
      if (RST) begin
        shadow_r[s] <= PC_RESET;
      end else if (push && (shadow_ptr_r == PTR_W'(s))) begin
        shadow_r[s] <= push_value;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking

  a_reset_clears_pc: assert property ( // RULE3
    RST |=> (pc_r == PC_RESET) && (ptr_r == PTR_RESET)
  ) else $error("Reset did not clear the program counter");

  a_low_write_load: assert property ( // RULE4
    disable iff (RST)
    (CMD.op == WRITE_LOW)
    |=> pc_r == {$past(latch_r[LATCH_HIGH_MSB:0]), $past(CMD.low_wdata)}
  ) else $error("Low byte write loaded wrong upper bits");

  a_computed_branch: assert property ( // RULE4
    disable iff (RST)
    (CMD.op == ADD_WORKING_TO_FILE_OP)
    |=> (pc_r[PC_W-1:LOW_W] == $past(latch_r[LATCH_HIGH_MSB:0]))
        && (pc_r[LOW_W-1:0] == LOW_W'($past(pc_r[LOW_W-1:0]) + $past(CMD.low_wdata)))
  ) else $error("Computed branch target is wrong");

  a_call_page_bits: assert property ( // RULE5
    disable iff (RST)
    ((CMD.op == CALL) || (CMD.op == JUMP))
    |=> pc_r == {$past(latch_r[LATCH_PAGE_MSB:LATCH_PAGE_LSB]), $past(CMD.target)}
  ) else $error("Call or jump used wrong page bits");

  a_push_advances: assert property ( // RULE7
    disable iff (RST)
    push |=> ptr_r == PTR_W'($past(ptr_r) + PTR_ONE)
  ) else $error("Push did not advance the stack pointer");

  a_pop_wraps: assert property ( // RULE16
    disable iff (RST)
    pop |=> ptr_r == PTR_W'($past(ptr_r) - PTR_ONE)
  ) else $error("Pop did not step the stack pointer back");

  a_return_restores: assert property ( // RULE9
    disable iff (RST)
    pop |=> pc_r == $past(top)
  ) else $error("Return did not restore the full counter");

  a_call_return_pair: assert property ( // RULE8
    disable iff (RST)
    (CMD.op == CALL) ##1 (CMD.op == RETURN_PLAIN)
    |=> pc_r == PC_W'($past(pc_r, 2) + PC_ONE)
  ) else $error("Return did not land after the call");

  a_irq_return_pair: assert property ( // RULE7
    disable iff (RST)
    (CMD.op == IRQ_ENTRY) ##1 (CMD.op == RETURN_FROM_INTERRUPT_OP)
    |=> pc_r == $past(pc_r, 2)
  ) else $error("Interrupt return did not resume the interrupted address");

  a_latch_kept: assert property ( // RULE10
    disable iff (RST)
    ((push || pop) && !CMD.latch_we) |=> $stable(latch_r)
  ) else $error("Stack operation changed the high-byte latch");

  a_ninth_push_wraps: assert property ( // RULE11
    disable iff (RST)
    push [*8] |=> ptr_r == $past(ptr_r, 8)
  ) else $error("Eight pushes did not wrap the pointer");

  a_step_increments: assert property ( // RULE1
    disable iff (RST)
    (CMD.op == STEP) |=> pc_r == PC_W'($past(pc_r) + PC_ONE)
  ) else $error("Step did not advance the program counter");

  a_hold_keeps_pc: assert property ( // RULE1
    disable iff (RST)
    (CMD.op == HOLD) |=> $stable(pc_r)
  ) else $error("Hold changed the program counter");

  a_latch_write_lands: assert property ( // RULE2
    disable iff (RST)
    CMD.latch_we |=> latch_r == ($past(CMD.latch_wdata) & LATCH_MASK)
  ) else $error("High-byte latch write did not land");

  a_latch_upper_zero: assert property ( // RULE2
    disable iff (RST)
    latch_r[LATCH_W-1:HIGH_W] == 3'h0
  ) else $error("Unused high-byte latch bits are not zero");

  a_irq_vector: assert property ( // RULE7
    disable iff (RST)
    (CMD.op == IRQ_ENTRY) |=> pc_r == IRQ_VECTOR
  ) else $error("Interrupt entry did not reach the vector");

  a_push_top_value: assert property ( // RULE7
    disable iff (RST)
    push |=> top == $past(push_value)
  ) else $error("Pushed return address is not on top of the stack");

  a_pop_matches_ref: assert property ( // RULE16
    disable iff (RST)
    pop |=> pc_r == $past(shadow_top)
  ) else $error("Popped address differs from the reference stack");

  a_jump_no_push: assert property ( // RULE5
    disable iff (RST)
    (CMD.op == JUMP) |=> ptr_r == $past(ptr_r)
  ) else $error("Jump moved the stack pointer");

  a_pointer_tracks: assert property ( // RULE6
    disable iff (RST)
    ptr_r == shadow_ptr_r
  ) else $error("Stack pointer left the reference count");

  c_call_return: cover property (
    disable iff (RST)
    (CMD.op == CALL) ##1 (CMD.op == RETURN_WITH_LITERAL_OP)
  );

  c_irq_entry_exit: cover property (
    disable iff (RST)
    (CMD.op == IRQ_ENTRY) ##[1:20] (CMD.op == RETURN_FROM_INTERRUPT_OP)
  );

  c_stack_wrap: cover property (
    disable iff (RST)
    push [*8] ##1 push
  );

  c_page_jump: cover property (
    disable iff (RST)
    (CMD.op == JUMP) && (latch_r[LATCH_PAGE_MSB:LATCH_PAGE_LSB] != 2'b00)
  );

  c_empty_pop: cover property (
    disable iff (RST)
    pop && (ptr_r == PTR_RESET)
  );

endmodule
`default_nettype wire

// ---- hdl/pc_stack_mem.sv ----
// Eight-entry return address memory with registered top-of-stack read
`timescale 1ns/1ps
`default_nettype none
module pc_stack_mem
  import pc_seq_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic wr_en,
  input  wire ptr_t wr_addr,
  input  wire pc_t  wr_data,
  input  wire ptr_t rd_addr,
  output pc_t       rd_data_r
);

  pc_t entry_r [STACK_DEPTH];

  // ---------------------------------------------------------------
  // Storage, one register per entry
  // ---------------------------------------------------------------
  for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_entry
    always_ff @(posedge clk) begin
      if (rst) begin
        entry_r[g] <= PC_RESET;
      end else if (wr_en && (wr_addr == PTR_W'(g))) begin
        entry_r[g] <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read register, bypassing a write to the same entry
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_r <= PC_RESET;
    end else if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_r <= wr_data;
    end else begin
      rd_data_r <= entry_r[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ---- hdl/pc_target_mux.sv ----
// Next program counter and return address selection
`timescale 1ns/1ps
`default_nettype none
module pc_target_mux
  import pc_seq_pkg::*;
(
  input  wire seq_cmd_t           cmd,
  input  wire pc_t                pc,
  input  wire logic [LATCH_W-1:0] latch,
  input  wire pc_t                top,
  output pc_t                     pc_nxt,
  output pc_t                     ret_addr
);

  function automatic pc_t pc_incr(input pc_t value);
    pc_incr = PC_W'(value + PC_ONE);
  endfunction

  logic [HIGH_W-1:0]   high_from_latch;
  logic [PAGE_W-1:0]   page_from_latch;
  logic [LOW_W-1:0]    low_sum;

  assign high_from_latch = latch[LATCH_HIGH_MSB:0];
  assign page_from_latch = latch[LATCH_PAGE_MSB:LATCH_PAGE_LSB];
  // Carry out of the low byte is dropped; the upper bits come from the latch
  assign low_sum         = LOW_W'(pc[LOW_W-1:0] + cmd.low_wdata);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  always_comb begin
    ret_addr = (cmd.op == CALL) ? pc_incr(pc) : pc;
    case (cmd.op)
      STEP:                     pc_nxt = pc_incr(pc);
      HOLD:                     pc_nxt = pc;
      WRITE_LOW:                pc_nxt = {high_from_latch, cmd.low_wdata}; // RULE4
      ADD_WORKING_TO_FILE_OP:   pc_nxt = {high_from_latch, low_sum}; // RULE4
      CALL,
      JUMP:                     pc_nxt = {page_from_latch, cmd.target}; // RULE5
      RETURN_PLAIN,
      RETURN_WITH_LITERAL_OP,
      RETURN_FROM_INTERRUPT_OP: pc_nxt = top; // RULE9
      IRQ_ENTRY:                pc_nxt = IRQ_VECTOR;
      default:                  pc_nxt = pc_incr(pc);
    endcase
  end

endmodule
`default_nettype wire
